//--- hw/pic_counter.sv
// programmable interval counter: control/status, preset/capture, counter
// Functional notes
// - error flag on flag overrun, clears on start
// - bit 11 picks oscillator or maintenance pulse
// - bit 10 write gives one divider pulse
// - bit 9 write acts as event 2
// - bit 8 write acts as event 1
// - overflow flag sets, software writes zero clears
// - overflow interrupt request when enabled
// - bits 5..3 select counting rate
// - bits 2..1 select operating mode
// - run bit starts activity, event can set
// - reset clears run; mode 0 overflow too
// - offset 2 preset, loaded on start
// - modes 2/3 offset 2 reads capture
// - mode 1 overflow reloads preset, keeps running
// - event modes start zero, event captures, flags
// - mode 3 event also zeroes counter
// - event-to-run enable sets run, start clears it
`timescale 1ns/1ps
module pic_counter import pic_pkg::*; (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [REG_W-1:0] reg_wdata_i,
	output logic [REG_W-1:0] reg_rdata_o,
	input wire logic event_input_1_i,
	input wire logic event_input_2_i,
	input wire logic line_event_i,
	output logic ovf_irq_o,
	output logic event2_irq_o
);
	// reset enters asynchronously but leaves on a clock edge, so no flop sees a partial release
	logic [1:0] rst_sync_ff;
	logic rstn;
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rstn = rst_sync_ff[1];

	pic_div_if #(.STAGES(DEC_STAGES)) div_if ();
	pic_decade_div #(.STAGES(DEC_STAGES)) u_div (
		.clock_i(clock_i),
		.rstn_i(rstn),
		.dv(div_if.div)
	);

	// input synchronisers: stage 0 is only read by stage 1
	logic [2:0] ev1_sync_ff, ev2_sync_ff, line_sync_ff;
	always_ff @(posedge clock_i or negedge rstn) begin
		if (!rstn) begin
			ev1_sync_ff <= 3'h0;
			ev2_sync_ff <= 3'h0;
			line_sync_ff <= 3'h0;
		end else begin
			ev1_sync_ff <= {ev1_sync_ff[1:0], event_input_1_i};
			ev2_sync_ff <= {ev2_sync_ff[1:0], event_input_2_i};
			line_sync_ff <= {line_sync_ff[1:0], line_event_i};
		end
	end

	logic run_ff, ovf_ff, oie_ff, msel_ff, err_ff, e2re_ff, e2ie_ff, e2f_ff;
	logic [1:0] mode_ff;
	logic [2:0] rate_ff;
	logic [CNT_W-1:0] count_ff, preset_ff, capture_ff;
	logic [$clog2(OSC_DIV)-1:0] osc_cnt_ff;
	logic [REG_W-1:0] rdata_ff;
	logic nxt_run, nxt_ovf, nxt_oie, nxt_msel, nxt_err, nxt_e2re, nxt_e2ie, nxt_e2f;
	logic [1:0] nxt_mode;
	logic [2:0] nxt_rate;
	logic [CNT_W-1:0] nxt_count, nxt_preset, nxt_capture;
	logic [$clog2(OSC_DIV)-1:0] nxt_osc_cnt;
	logic [REG_W-1:0] nxt_rdata;
	logic wr_csr, wr_pcr, osc_tick, ev1_trig, ev2_trig, line_tick, count_en;
	logic e2f_set, sw_start, ev_start, start, wrap;

	always_comb begin
		wr_csr = reg_wr_i && (reg_addr_i == CSR_OFF);
		wr_pcr = reg_wr_i && (reg_addr_i == PCR_OFF);
		osc_tick = (osc_cnt_ff == ($clog2(OSC_DIV))'(OSC_DIV - 1));
		nxt_osc_cnt = osc_tick ? '0 : osc_cnt_ff + 1'b1;
		// maintenance pulse replaces the oscillator, so the divider can be stepped by hand
		div_if.src_tick = msel_ff ? (wr_csr & reg_wdata_i[MPULSE_BIT]) : osc_tick;
		ev1_trig = (ev1_sync_ff[1] & ~ev1_sync_ff[2]) | (wr_csr & reg_wdata_i[E1T_BIT]);
		ev2_trig = (ev2_sync_ff[1] & ~ev2_sync_ff[2]) | (wr_csr & reg_wdata_i[E2T_BIT]);
		line_tick = line_sync_ff[1] & ~line_sync_ff[2];
		case (rate_ff)
			RATE_STOP: count_en = 1'b0;
			RATE_EV1: count_en = ev1_trig;
			RATE_LINE: count_en = line_tick;
			default: count_en = div_if.rate_tick[rate_ff - 3'h1];
		endcase
	end

	always_comb begin
		nxt_run = run_ff;
		nxt_ovf = ovf_ff;
		nxt_oie = oie_ff;
		nxt_msel = msel_ff;
		nxt_err = err_ff;
		nxt_e2re = e2re_ff;
		nxt_e2ie = e2ie_ff;
		nxt_e2f = e2f_ff;
		nxt_mode = mode_ff;
		nxt_rate = rate_ff;
		nxt_count = count_ff;
		nxt_preset = preset_ff;
		nxt_capture = capture_ff;
		if (wr_csr) begin
			nxt_run = reg_wdata_i[RUN_BIT];
			nxt_mode = reg_wdata_i[MODE_LSB +: 2];
			nxt_rate = reg_wdata_i[RATE_LSB +: 3];
			nxt_oie = reg_wdata_i[OIE_BIT];
			nxt_msel = reg_wdata_i[MSEL_BIT];
			nxt_err = reg_wdata_i[ERR_BIT];
			nxt_e2re = reg_wdata_i[E2RE_BIT];
			nxt_e2ie = reg_wdata_i[E2IE_BIT];
			// flags take only a written zero
			nxt_ovf = ovf_ff & reg_wdata_i[OVF_BIT];
			nxt_e2f = e2f_ff & reg_wdata_i[E2F_BIT];
		end
		if (wr_pcr) begin
			nxt_preset = reg_wdata_i;
		end
		e2f_set = ev2_trig & (run_ff | e2re_ff);
		sw_start = wr_csr & reg_wdata_i[RUN_BIT] & ~run_ff;
		ev_start = e2f_set & e2re_ff;
		// a rate tick landing on the start cycle is dropped, the load takes priority
		start = sw_start | ev_start;
		wrap = run_ff & ~start & count_en & (count_ff == CNT_ALL_ONES);
		if (start) begin
			nxt_run = 1'b1;
			nxt_ovf = 1'b0;
			nxt_err = 1'b0;
			nxt_e2re = 1'b0;
			if (!e2re_ff) begin
				nxt_e2f = 1'b0;
			end
			// a mode written together with the run bit applies at once
			if (nxt_mode[1]) begin
				nxt_count = '0;
				nxt_capture = '0;
			end else begin
				nxt_count = wr_pcr ? reg_wdata_i : preset_ff;
			end
		end else if (run_ff && count_en) begin
			nxt_count = count_ff + 1'b1;
			if (wrap) begin
				case (mode_ff)
					MODE_SINGLE: nxt_run = 1'b0;
					// run stays as written, so a software stop on the wrap cycle still holds
					MODE_REPEAT: nxt_count = preset_ff;
					default: nxt_count = '0;
				endcase
			end
		end
		if (run_ff && !start && mode_ff[1] && ev2_trig) begin
			nxt_capture = count_ff;
			if (mode_ff == MODE_CAPCLR) begin
				nxt_count = '0;
			end
		end
		// hardware sets win over a software clear in the same cycle
		if (wrap) begin
			nxt_ovf = 1'b1;
			if (ovf_ff) begin
				nxt_err = 1'b1;
			end
		end
		if (e2f_set) begin
			nxt_e2f = 1'b1;
			if (e2f_ff) begin
				nxt_err = 1'b1;
			end
		end
		nxt_rdata = rdata_ff;
		if (reg_rd_i) begin
			case (reg_addr_i)
				CSR_OFF: nxt_rdata = {e2f_ff, e2ie_ff, e2re_ff, err_ff, msel_ff, 3'h0,
					ovf_ff, oie_ff, rate_ff, mode_ff, run_ff};
				PCR_OFF: nxt_rdata = mode_ff[1] ? capture_ff : preset_ff;
				default: nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rstn) begin
		if (!rstn) begin
			run_ff <= CSR_RESET[RUN_BIT];
			ovf_ff <= CSR_RESET[OVF_BIT];
			oie_ff <= CSR_RESET[OIE_BIT];
			msel_ff <= CSR_RESET[MSEL_BIT];
			err_ff <= CSR_RESET[ERR_BIT];
			e2re_ff <= CSR_RESET[E2RE_BIT];
			e2ie_ff <= CSR_RESET[E2IE_BIT];
			e2f_ff <= CSR_RESET[E2F_BIT];
			mode_ff <= CSR_RESET[MODE_LSB +: 2];
			rate_ff <= CSR_RESET[RATE_LSB +: 3];
			count_ff <= '0;
			preset_ff <= PRESET_RESET;
			capture_ff <= '0;
			osc_cnt_ff <= '0;
			rdata_ff <= '0;
		end else begin
			run_ff <= nxt_run;
			ovf_ff <= nxt_ovf;
			oie_ff <= nxt_oie;
			msel_ff <= nxt_msel;
			err_ff <= nxt_err;
			e2re_ff <= nxt_e2re;
			e2ie_ff <= nxt_e2ie;
			e2f_ff <= nxt_e2f;
			mode_ff <= nxt_mode;
			rate_ff <= nxt_rate;
			count_ff <= nxt_count;
			preset_ff <= nxt_preset;
			capture_ff <= nxt_capture;
			osc_cnt_ff <= nxt_osc_cnt;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign ovf_irq_o = ovf_ff & oie_ff;
	assign event2_irq_o = e2f_ff & e2ie_ff;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn);

	start_load_a: assert property (sw_start && !nxt_mode[1] && !wr_pcr |=> count_ff == $past(preset_ff))
		else $error("preset not loaded on start");
	event_start_a: assert property (sw_start && nxt_mode[1] |=> count_ff == '0 && capture_ff == '0)
		else $error("event mode start did not clear");
	wrap_flag_a: assert property (wrap |=> ovf_ff)
		else $error("overflow flag missed");
	single_stop_a: assert property (wrap && mode_ff == MODE_SINGLE && !wr_csr |=> !run_ff)
		else $error("single interval kept running");
	repeat_reload_a: assert property (wrap && mode_ff == MODE_REPEAT && !wr_csr |=> run_ff && count_ff == $past(preset_ff))
		else $error("repeat mode did not reload");
	overrun_err_a: assert property ((wrap && ovf_ff) || (e2f_set && e2f_ff) |=> err_ff)
		else $error("overrun not flagged");
	capture_val_a: assert property (run_ff && !start && mode_ff[1] && ev2_trig |=> capture_ff == $past(count_ff))
		else $error("capture value wrong");
	capclr_zero_a: assert property (run_ff && !start && mode_ff == MODE_CAPCLR && ev2_trig |=> count_ff == '0)
		else $error("mode 3 did not zero counter");
	ev_run_a: assert property (e2f_set && e2re_ff |=> run_ff && !e2re_ff && e2f_ff)
		else $error("event did not start run");
	wo_zero_a: assert property (reg_rd_i && reg_addr_i == CSR_OFF |=> reg_rdata_o[10:8] == 3'h0)
		else $error("write-only bits read nonzero");
	maint_gate_a: assert property (msel_ff && !(wr_csr && reg_wdata_i[MPULSE_BIT]) |-> !div_if.src_tick)
		else $error("divider ticked without maintenance pulse");
	stop_hold_a: assert property (run_ff && rate_ff == RATE_STOP && !wr_csr && !ev2_trig |=> $stable(count_ff))
		else $error("stopped rate still counted");
	irq_level_a: assert property (wrap && oie_ff && !wr_csr |=> ovf_irq_o)
		else $error("overflow interrupt not requested");

	// start path side effects, then counting, hold, read-back and event flag checks
	run_start_a: assert property (sw_start
		|=> run_ff)
		else $error("run bit not set on start");
	err_clear_a: assert property (start && !(e2f_set && e2f_ff)
		|=> !err_ff)
		else $error("error flag survived start");
	ovf_clear_a: assert property (start
		|=> !ovf_ff)
		else $error("overflow flag survived start");
	e2re_clear_a: assert property (start
		|=> !e2re_ff)
		else $error("event-to-run enable survived start");
	count_step_a: assert property (run_ff && !start && count_en && !wrap && !(mode_ff[1] && ev2_trig)
		|=> count_ff == $past(count_ff) + 16'h1)
		else $error("counter did not step by one");
	line_hold_a: assert property (run_ff && !start && rate_ff == RATE_LINE && !line_tick && !(mode_ff[1] && ev2_trig)
		|=> $stable(count_ff))
		else $error("line rate counted without an edge");
	preset_hold_a: assert property (!wr_pcr
		|=> preset_ff == $past(preset_ff))
		else $error("preset changed without a write");
	capture_ro_a: assert property (!start && !(run_ff && mode_ff[1] && ev2_trig)
		|=> capture_ff == $past(capture_ff))
		else $error("capture changed without an event");
	pcr_read_a: assert property (reg_rd_i && reg_addr_i == PCR_OFF && mode_ff[1]
		|=> reg_rdata_o == $past(capture_ff))
		else $error("offset 2 did not read capture");
	e2f_set_a: assert property (e2f_set
		|=> e2f_ff)
		else $error("event flag not set");

	cov_single_c: cover property (wrap && mode_ff == MODE_SINGLE);
	cov_repeat_c: cover property (wrap && mode_ff == MODE_REPEAT);
	cov_capclr_c: cover property (run_ff && mode_ff == MODE_CAPCLR && ev2_trig);
	cov_evstart_c: cover property (ev_start);
	cov_capture_c: cover property (run_ff && mode_ff == MODE_CAPTURE && ev2_trig);
endmodule : pic_counter

//--- hw/pic_decade_div.sv
// decade divider chain giving the counting rate enables
`timescale 1ns/1ps
module pic_decade_div import pic_pkg::*; #(
	parameter int STAGES = DEC_STAGES
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	pic_div_if.div dv
);
	logic [STAGES:0] stage_in;

	assign stage_in[0] = dv.src_tick;

	for (genvar k = 0; k < STAGES; k++) begin : g_stage
		logic [3:0] cnt_ff;
		logic [3:0] nxt_cnt;
		always_comb begin
			nxt_cnt = cnt_ff;
			if (stage_in[k]) begin
				nxt_cnt = (cnt_ff == DEC_LAST) ? 4'h0 : cnt_ff + 4'h1;
			end
		end
		always_ff @(posedge clock_i or negedge rstn_i) begin
			if (!rstn_i) begin
				cnt_ff <= 4'h0;
			end else begin
				cnt_ff <= nxt_cnt;
			end
		end
		// one pulse per ten input ticks; stage k feeds stage k+1
		assign stage_in[k+1] = stage_in[k] & (cnt_ff == DEC_LAST);
		assign dv.rate_tick[k] = stage_in[k+1];
	end
endmodule : pic_decade_div

//--- hw/pic_div_if.sv
// link between counter control and its decade divider
`timescale 1ns/1ps
interface pic_div_if #(parameter int STAGES = 5);
	logic src_tick;
	logic [STAGES-1:0] rate_tick;
	modport ctl (output src_tick, input rate_tick);
	modport div (input src_tick, output rate_tick);
endinterface : pic_div_if

//--- hw/pic_pkg.sv
// shared constants for the programmable interval counter
package pic_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int OSC_HZ = 10_000_000;
	localparam int OSC_DIV = CLK_HZ / OSC_HZ;
	localparam int DEC_STAGES = 5;
	localparam logic [3:0] DEC_LAST = 4'h9;
	localparam int CNT_W = 16;
	localparam int REG_W = 16;
	localparam logic [1:0] CSR_OFF = 2'h0;
	localparam logic [1:0] PCR_OFF = 2'h2;
	localparam int E2F_BIT = 15;
	localparam int E2IE_BIT = 14;
	localparam int E2RE_BIT = 13;
	localparam int ERR_BIT = 12;
	localparam int MSEL_BIT = 11;
	localparam int MPULSE_BIT = 10;
	localparam int E2T_BIT = 9;
	localparam int E1T_BIT = 8;
	localparam int OVF_BIT = 7;
	localparam int OIE_BIT = 6;
	localparam int RATE_LSB = 3;
	localparam int MODE_LSB = 1;
	localparam int RUN_BIT = 0;
	localparam logic [15:0] CSR_RESET = 16'h0000;
	localparam logic [15:0] PRESET_RESET = 16'h0000;
	localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_REPEAT = 2'h1;
	localparam logic [1:0] MODE_CAPTURE = 2'h2;
	localparam logic [1:0] MODE_CAPCLR = 2'h3;
	localparam logic [2:0] RATE_STOP = 3'h0;
	localparam logic [2:0] RATE_EV1 = 3'h6;
	localparam logic [2:0] RATE_LINE = 3'h7;
endpackage : pic_pkg

//--- verif/pic_host_model.sv
// host-side register bus and event pin model for the interval counter
`timescale 1ns/1ps
module pic_host_model (
	input wire logic clock_i,
	output logic [1:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [15:0] reg_wdata_o,
	input wire logic [15:0] reg_rdata_i,
	output logic [2:0] pin_o
);
	initial begin
		reg_addr_o = 2'h0;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 16'h0000;
		pin_o = 3'h0;
	end
	// released lines show the inverse so stale values cannot pass
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clock_i);
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= 1'b1;
		@(posedge clock_i);
		reg_wr_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge clock_i);
		reg_addr_o <= a;
		reg_rd_o <= 1'b1;
		@(posedge clock_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		#1 d = reg_rdata_i;
	endtask : rd
	// low for three cycles after each pulse so the edge detector rearms
	task automatic pulse(input int n);
		@(posedge clock_i);
		pin_o[n] <= 1'b1;
		repeat (2) @(posedge clock_i);
		pin_o[n] <= 1'b0;
		repeat (3) @(posedge clock_i);
	endtask : pulse
endmodule : pic_host_model

//--- verif/tb_top.sv
// self-checking testbench for the interval counter
`timescale 1ns/1ps
module tb_top;
	logic clock_i;
	logic resetn_i;
	logic [1:0] addr;
	logic wr;
	logic rd;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [2:0] pins;
	logic ovf_irq;
	logic e2_irq;
	int bad_count = 0;
	int compares = 0;
	pic_host_model host_u (.clock_i(clock_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata), .pin_o(pins));
	pic_counter dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .event_input_1_i(pins[0]),
		.event_input_2_i(pins[1]), .line_event_i(pins[2]), .ovf_irq_o(ovf_irq), .event2_irq_o(e2_irq));
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	task automatic wrap_up;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
			bad_count++;
		end
	endtask : chk
	task automatic rc(input logic [1:0] a, input logic [15:0] e);
		logic [15:0] d;
		host_u.rd(a, d);
		chk(d, e);
	endtask : rc
	// bounded wait; running out ends the run
	task automatic wait_ovf(input int n);
		for (int i = 0; i < n && ovf_irq !== 1'b1; i++) @(posedge clock_i);
		if (ovf_irq !== 1'b1) begin
			$display("MISMATCH %0t overflow never came", $time);
			bad_count++;
			wrap_up();
		end
	endtask : wait_ovf
	task automatic t_regs;
		rc(2'h0, 16'h0000);
		rc(2'h2, 16'h0000);
		host_u.wr(2'h3, 16'hffff);
		rc(2'h1, 16'h0000);
		rc(2'h3, 16'h0000);
		rc(2'h0, 16'h0000);
		host_u.wr(2'h2, 16'h5a5a);
		rc(2'h2, 16'h5a5a);
	endtask : t_regs
	task automatic t_single;
		host_u.wr(2'h2, 16'hfffe);
		host_u.wr(2'h0, 16'h0049);
		wait_ovf(400);
		rc(2'h0, 16'h00c8);
		host_u.wr(2'h0, 16'h0048);
		rc(2'h0, 16'h0048);
		chk(16'(ovf_irq), 16'h0000);
	endtask : t_single
	task automatic t_repeat;
		host_u.wr(2'h2, 16'hffff);
		host_u.wr(2'h0, 16'h000b);
		repeat (260) @(posedge clock_i);
		rc(2'h0, 16'h108b);
		host_u.wr(2'h0, 16'h0082);
		host_u.wr(2'h0, 16'h0083);
		rc(2'h0, 16'h0003);
	endtask : t_repeat
	// two ticks needed: never before one period, always within two
	task automatic t_rate(input logic [2:0] r, input int p);
		host_u.wr(2'h0, 16'h0000);
		host_u.wr(2'h2, 16'hfffe);
		host_u.wr(2'h0, 16'h0041 | (16'(r) << 3));
		repeat (p - 10) @(posedge clock_i);
		chk(16'(ovf_irq), 16'h0000);
		wait_ovf(p + 40);
		host_u.wr(2'h0, 16'h0000);
	endtask : t_rate
	task automatic t_pins;
		host_u.wr(2'h0, 16'h0071);
		host_u.pulse(0);
		chk(16'(ovf_irq), 16'h0000);
		host_u.wr(2'h0, 16'h0171);
		repeat (6) @(posedge clock_i);
		chk(16'(ovf_irq), 16'h0001);
		rc(2'h0, 16'h00f0);
		host_u.wr(2'h0, 16'h0000);
		host_u.wr(2'h0, 16'h0079);
		host_u.pulse(2);
		chk(16'(ovf_irq), 16'h0000);
		host_u.pulse(2);
		chk(16'(ovf_irq), 16'h0001);
	endtask : t_pins
	task automatic t_capture;
		host_u.wr(2'h0, 16'h4035);
		repeat (3) host_u.pulse(0);
		host_u.pulse(1);
		rc(2'h2, 16'h0003);
		rc(2'h0, 16'hc035);
		chk(16'(e2_irq), 16'h0001);
		host_u.pulse(1);
		rc(2'h0, 16'hd035);
		host_u.wr(2'h2, 16'h1234);
		rc(2'h2, 16'h0003);
		host_u.wr(2'h0, 16'h4036);
		host_u.wr(2'h0, 16'h4037);
		rc(2'h2, 16'h0000);
		repeat (2) host_u.pulse(0);
		host_u.wr(2'h0, 16'h4237);
		repeat (6) @(posedge clock_i);
		rc(2'h2, 16'h0002);
		host_u.pulse(0);
		host_u.pulse(1);
		rc(2'h2, 16'h0001);
		host_u.wr(2'h0, 16'h2004);
		host_u.pulse(1);
		rc(2'h0, 16'h8005);
	endtask : t_capture
	// first overflow aligns the unknown divider phase, then exactly ten pulses
	task automatic t_maint;
		host_u.wr(2'h0, 16'h0800);
		host_u.wr(2'h2, 16'hffff);
		host_u.wr(2'h0, 16'h0849);
		repeat (300) @(posedge clock_i);
		chk(16'(ovf_irq), 16'h0000);
		for (int i = 0; i < 10 && ovf_irq !== 1'b1; i++) begin
			host_u.wr(2'h0, 16'h0c49);
			// let the flag settle first, else one more write restarts the stopped run
			@(posedge clock_i);
		end
		repeat (4) @(posedge clock_i);
		rc(2'h0, 16'h08c8);
		host_u.wr(2'h0, 16'h0849);
		repeat (9) host_u.wr(2'h0, 16'h0c49);
		repeat (4) @(posedge clock_i);
		chk(16'(ovf_irq), 16'h0000);
		host_u.wr(2'h0, 16'h0c49);
		repeat (4) @(posedge clock_i);
		chk(16'(ovf_irq), 16'h0001);
	endtask : t_maint
	initial begin
		resetn_i = 1'b0;
		repeat (16) @(posedge clock_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		t_regs();
		t_single();
		t_repeat();
		t_rate(3'h1, 100);
		t_rate(3'h2, 1000);
		t_rate(3'h3, 10000);
		host_u.wr(2'h0, 16'h0041);
		repeat (300) @(posedge clock_i);
		chk(16'(ovf_irq), 16'h0000);
		host_u.wr(2'h0, 16'h0000);
		t_pins();
		t_capture();
		t_maint();
		wrap_up();
	end
endmodule : tb_top
